// ### sbw_map.vh
// constants for the scan-to-service-access-bus word and block access block
`ifndef SBW_MAP_VH
`define SBW_MAP_VH

// =====================================================================
// instruction codes
`define SBW_IR_LEN        5
`define SBW_IR_WORD       5'h11
`define SBW_IR_BLOCK      5'h12
`define SBW_IR_CANCEL     5'h13
`define SBW_IR_BYPASS     5'h1F
`define SBW_IR_TAIL       2'h1

// =====================================================================
// data register layout
`define SBW_DR_MAX        35
`define SBW_DR_WORD_TOP   34
`define SBW_DR_BLOCK_TOP  33
`define SBW_WDATA_WORD_LO 3
`define SBW_WDATA_BLK_LO  2
`define SBW_ADDR_LEN      36

// =====================================================================
// access size codes
`define SBW_SIZE_BYTE     2'h0
`define SBW_SIZE_HALF     2'h1
`define SBW_SIZE_WORD     2'h2
`define SBW_INC_BYTE      36'h1
`define SBW_INC_HALF      36'h2
`define SBW_INC_WORD      36'h4

// =====================================================================
// scan controller states
`define SBW_ST_TLR        4'hF
`define SBW_ST_RTI        4'hC
`define SBW_ST_SEL_DR     4'h7
`define SBW_ST_CAP_DR     4'h6
`define SBW_ST_SH_DR      4'h2
`define SBW_ST_EX1_DR     4'h1
`define SBW_ST_PAU_DR     4'h3
`define SBW_ST_EX2_DR     4'h0
`define SBW_ST_UPD_DR     4'h5
`define SBW_ST_SEL_IR     4'h4
`define SBW_ST_CAP_IR     4'hE
`define SBW_ST_SH_IR      4'hA
`define SBW_ST_EX1_IR     4'h9
`define SBW_ST_PAU_IR     4'hB
`define SBW_ST_EX2_IR     4'h8
`define SBW_ST_UPD_IR     4'hD

`endif

// ### sbw_sync.v
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module sbw_sync #(
    parameter W = 1
) (
    // clock and reset
    input  wire         core_clk,
    input  wire         rstn,
    // async in, synced out
    input  wire [W-1:0] async_in,
    output reg  [W-1:0] sync_out
);
    reg [W-1:0] meta_q;

    // =================================================================
    // first flop feeds only the second flop
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            meta_q   <= {W{1'b0}};
            sync_out <= {W{1'b0}};
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule // sbw_sync

// ### sbw_tap.v
// scan controller state machine stepped on each sampled test-clock rise
`timescale 1ns/1ps
`include "sbw_map.vh"
module sbw_tap (
    // clock and reset
    input  wire       core_clk,
    input  wire       rstn,
    // sampled scan pins
    input  wire       step,
    input  wire       tms,
    // current state
    output reg  [3:0] state_q
);
    reg [3:0] state_d;

    // =================================================================
    // next state from tms
    always @* begin
        state_d = state_q;
        case (state_q)
            `SBW_ST_TLR:    state_d = tms ? `SBW_ST_TLR    : `SBW_ST_RTI;
            `SBW_ST_RTI:    state_d = tms ? `SBW_ST_SEL_DR : `SBW_ST_RTI;
            `SBW_ST_SEL_DR: state_d = tms ? `SBW_ST_SEL_IR : `SBW_ST_CAP_DR;
            `SBW_ST_CAP_DR: state_d = tms ? `SBW_ST_EX1_DR : `SBW_ST_SH_DR;
            `SBW_ST_SH_DR:  state_d = tms ? `SBW_ST_EX1_DR : `SBW_ST_SH_DR;
            `SBW_ST_EX1_DR: state_d = tms ? `SBW_ST_UPD_DR : `SBW_ST_PAU_DR;
            `SBW_ST_PAU_DR: state_d = tms ? `SBW_ST_EX2_DR : `SBW_ST_PAU_DR;
            `SBW_ST_EX2_DR: state_d = tms ? `SBW_ST_UPD_DR : `SBW_ST_SH_DR;
            `SBW_ST_UPD_DR: state_d = tms ? `SBW_ST_SEL_DR : `SBW_ST_RTI;
            `SBW_ST_SEL_IR: state_d = tms ? `SBW_ST_TLR    : `SBW_ST_CAP_IR;
            `SBW_ST_CAP_IR: state_d = tms ? `SBW_ST_EX1_IR : `SBW_ST_SH_IR;
            `SBW_ST_SH_IR:  state_d = tms ? `SBW_ST_EX1_IR : `SBW_ST_SH_IR;
            `SBW_ST_EX1_IR: state_d = tms ? `SBW_ST_UPD_IR : `SBW_ST_PAU_IR;
            `SBW_ST_PAU_IR: state_d = tms ? `SBW_ST_EX2_IR : `SBW_ST_PAU_IR;
            `SBW_ST_EX2_IR: state_d = tms ? `SBW_ST_UPD_IR : `SBW_ST_SH_IR;
            `SBW_ST_UPD_IR: state_d = tms ? `SBW_ST_SEL_DR : `SBW_ST_RTI;
            default:        state_d = `SBW_ST_TLR;
        endcase
    end

    // =================================================================
    // state advances only on a test-clock rise
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= `SBW_ST_TLR;
        end else if (step) begin
            state_q <= state_d;
        end
    end
endmodule // sbw_tap

// ### sbw_top.v
// scan port word/block access and cancel onto the service access bus
`timescale 1ns/1ps
`include "sbw_map.vh"
module sbw_top (
    // clock and reset
    input  wire                     core_clk,
    input  wire                     rstn,
    // scan pins
    input  wire                     tck,
    input  wire                     tms,
    input  wire                     tdi,
    output reg                      tdo_q,
    output reg                      tdo_oe_q,
    // device protection state, core clock domain
    input  wire                     protect,
    // service access bus master side
    output reg                      sab_req_q,
    output reg                      sab_wr_q,
    output reg  [1:0]               sab_size_q,
    output reg  [`SBW_ADDR_LEN-1:0] sab_addr_q,
    output reg  [31:0]              sab_wdata_q,
    output reg                      sab_cancel_q,
    input  wire                     sab_done,
    input  wire                     sab_err,
    input  wire [31:0]              sab_rdata
);

    // =================================================================
    // how the block works
    // all pins are sampled by the core clock, so the scan side runs in
    // the core domain and needs no second clock tree
    // the test clock must stay level for three core clocks each half,
    // otherwise an edge is lost between the two sampling flops
    // each scan action happens on the core edge after a rise is seen,
    // about three core clocks after the pin moved
    // tdo moves after a fall, so the master sees a settled bit at rise
    // the sampling delay is paid twice per test-clock period; this caps
    // the test clock at well under a sixth of the core clock
    // only one bus access is ever outstanding; busy covers it from the
    // request to the core edge after done
    // every data scan remembers busy as shown at capture; if it was set,
    // the update does nothing and the master simply scans again
    // deciding on the live flag instead would let a scan that showed
    // busy still toggle the phase, and the master would lose its place
    // truncated read scans are harmless: only update moves any state
    // the word register is 35 bits with the direction in bit 0 on
    // address scans; the block register uses the low 34 bits only
    // error is cleared when a new access starts and set when one fails
    // or completes under an abort; an abort counts as a timeout
    // an abort is raised only while an access is outstanding at the
    // update of the cancel code; otherwise that code does nothing
    // only word sized accesses are issued, so block mode always steps
    // the address by four
    // a block read fetches one location ahead at each update, so the
    // last update of a run reads one word that nobody collects
    // a block write takes its data from the scan that just ended
    // any code other than word, block and cancel acts as a one-bit
    // bypass; test-logic-reset restores it and the address phase
    // the protection input is a core-domain level and is not synced
    // tdo_q rests low outside the shift states
    // =================================================================
    // pin synchronisation
    wire [2:0] pins_s;
    wire       tck_s = pins_s[2];
    wire       tms_s = pins_s[1];
    wire       tdi_s = pins_s[0];

    sbw_sync #(
        .W (3)
    ) u_sync (
        .core_clk (core_clk),
        .rstn     (rstn),
        .async_in ({tck, tms, tdi}),
        .sync_out (pins_s)
    );

    // edge detect on the synced test clock
    // tck_q resets low like the idle pin, so release gives no false rise
    reg  tck_q;
    wire tck_rise = tck_s & ~tck_q;
    wire tck_fall = ~tck_s & tck_q;

    // =================================================================
    // scan controller
    wire [3:0] tap_state;

    sbw_tap u_tap (
        .core_clk (core_clk),
        .rstn     (rstn),
        .step     (tck_rise),
        .tms      (tms_s),
        .state_q  (tap_state)
    );

    // =================================================================
    // state registers
    reg [`SBW_IR_LEN-1:0] ir_q;         // active instruction
    reg [`SBW_IR_LEN-1:0] ir_sh_q;      // instruction shift stage
    reg [`SBW_DR_MAX-1:0] dr_q;         // data shift stage
    reg                   phase_data_q; // 0 address phase, 1 data phase
    reg                   busy_q;       // bus access outstanding
    reg                   err_q;        // last access failed or timed out
    reg [31:0]            rdata_q;      // last read result
    reg                   scan_busy_q;  // busy as shown by the current scan

    // instruction decode
    wire is_word   = (ir_q == `SBW_IR_WORD);
    wire is_block  = (ir_q == `SBW_IR_BLOCK);
    wire is_cancel = (ir_q == `SBW_IR_CANCEL);

    // address step for block mode follows the stored size
    // only word size is ever stored here; byte and half steps are spare
    reg [`SBW_ADDR_LEN-1:0] addr_inc;
    always @* begin
        case (sab_size_q)
            `SBW_SIZE_BYTE: addr_inc = `SBW_INC_BYTE;
            `SBW_SIZE_HALF: addr_inc = `SBW_INC_HALF;
            default:        addr_inc = `SBW_INC_WORD;
        endcase
    end
    wire [`SBW_ADDR_LEN-1:0] addr_next = sab_addr_q + addr_inc;

    // =================================================================
    // capture and shift values for the data register
    reg [`SBW_DR_MAX-1:0] dr_cap;
    reg [`SBW_DR_MAX-1:0] dr_shift;
    always @* begin
        dr_cap   = {`SBW_DR_MAX{1'b0}};
        dr_shift = {`SBW_DR_MAX{1'b0}};
        if (is_word) begin
            if (phase_data_q && !sab_wr_q)
                dr_cap = {1'b0, err_q, busy_q, rdata_q};
            else
                dr_cap = {33'h0, err_q, busy_q};
            dr_shift = {tdi_s, dr_q[`SBW_DR_WORD_TOP:1]};
        end else if (is_block) begin
            if (!sab_wr_q)
                dr_cap = {1'b0, err_q, busy_q, rdata_q};
            else
                dr_cap = {33'h0, err_q, busy_q};
            dr_shift = {1'b0, tdi_s, dr_q[`SBW_DR_BLOCK_TOP:1]};
        end else if (!is_cancel) begin
            // one-bit bypass for every other code
            dr_shift = {34'h0, tdi_s};
        end
    end

    // write data sits at the top of each path; the low bits are don't-care
    wire [31:0] wdata_word  = dr_q[`SBW_DR_WORD_TOP:`SBW_WDATA_WORD_LO];
    wire [31:0] wdata_block = dr_q[`SBW_DR_BLOCK_TOP:`SBW_WDATA_BLK_LO];

    // =================================================================
    // scan actions on test-clock edges and bus completion
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            tck_q        <= 1'b0;
            tdo_q        <= 1'b0;
            tdo_oe_q     <= 1'b0;
            ir_q         <= `SBW_IR_BYPASS;
            ir_sh_q      <= {`SBW_IR_LEN{1'b0}};
            dr_q         <= {`SBW_DR_MAX{1'b0}};
            phase_data_q <= 1'b0;
            busy_q       <= 1'b0;
            err_q        <= 1'b0;
            rdata_q      <= 32'h0;
            scan_busy_q  <= 1'b0;
            sab_req_q    <= 1'b0;
            sab_wr_q     <= 1'b0;
            sab_size_q   <= `SBW_SIZE_WORD;
            sab_addr_q   <= {`SBW_ADDR_LEN{1'b0}};
            sab_wdata_q  <= 32'h0;
            sab_cancel_q <= 1'b0;
        end else begin
            tck_q <= tck_s;

            // bus completion frees the port; a cancelled access reports timeout
            // a done pulse with nothing outstanding is ignored
            if (busy_q && sab_done) begin
                busy_q       <= 1'b0;
                sab_req_q    <= 1'b0;
                sab_cancel_q <= 1'b0;
                err_q        <= sab_err | sab_cancel_q;
                if (!sab_wr_q)
                    rdata_q <= sab_rdata;
            end

            if (tck_rise) begin
                case (tap_state)
                    `SBW_ST_TLR: begin
                        ir_q         <= `SBW_IR_BYPASS;
                        phase_data_q <= 1'b0;
                    end
                    `SBW_ST_CAP_IR: begin
                        ir_sh_q <= {protect, err_q, busy_q, `SBW_IR_TAIL};
                    end
                    `SBW_ST_SH_IR: begin
                        ir_sh_q <= {tdi_s, ir_sh_q[`SBW_IR_LEN-1:1]};
                    end
                    `SBW_ST_UPD_IR: begin
                        ir_q <= ir_sh_q;
                        phase_data_q <= 1'b0;
                        if (ir_sh_q == `SBW_IR_CANCEL && busy_q && !sab_done)
                            sab_cancel_q <= 1'b1;
                        // a read run needs its first block location before the
                        // first data scan, so it is fetched while the master walks there
                        // block read prefetches the next location
                        if (ir_sh_q == `SBW_IR_BLOCK && !busy_q && !sab_wr_q) begin
                            sab_addr_q <= addr_next;
                            sab_req_q  <= 1'b1;
                            busy_q     <= 1'b1;
                            err_q      <= 1'b0;
                        end
                    end
                    `SBW_ST_CAP_DR: begin
                        dr_q <= dr_cap;
                        scan_busy_q <= busy_q;
                    end
                    `SBW_ST_SH_DR: begin
                        dr_q <= dr_shift;
                    end
                    `SBW_ST_UPD_DR: begin
                        if (!busy_q && !scan_busy_q && is_word) begin
                            phase_data_q <= ~phase_data_q;
                            if (!phase_data_q) begin
                                sab_addr_q <= {dr_q[`SBW_DR_WORD_TOP:1], 2'b00};
                                sab_size_q <= `SBW_SIZE_WORD;
                                sab_wr_q   <= ~dr_q[0];
                                // reads start now so data is ready for the next scan
                                if (dr_q[0]) begin
                                    sab_req_q <= 1'b1;
                                    busy_q    <= 1'b1;
                                    err_q     <= 1'b0;
                                end
                            end else if (sab_wr_q) begin
                                sab_wdata_q <= wdata_word;
                                sab_req_q   <= 1'b1;
                                busy_q      <= 1'b1;
                                err_q       <= 1'b0;
                            end
                        end else if (!busy_q && !scan_busy_q && is_block) begin
                            // next access starts on Update-DR, no idle needed
                            sab_addr_q <= addr_next;
                            sab_req_q  <= 1'b1;
                            busy_q     <= 1'b1;
                            err_q      <= 1'b0;
                            if (sab_wr_q)
                                sab_wdata_q <= wdata_block;
                        end
                    end
                    default: begin
                    end
                endcase
            end

            // tdo changes on the falling test clock so the master samples a stable bit
            // the pin is enabled only while a shift state drives it
            if (tck_fall) begin
                tdo_oe_q <= (tap_state == `SBW_ST_SH_IR) | (tap_state == `SBW_ST_SH_DR);
                if (tap_state == `SBW_ST_SH_IR)
                    tdo_q <= ir_sh_q[0];
                else if (tap_state == `SBW_ST_SH_DR)
                    tdo_q <= dr_q[0];
                else
                    tdo_q <= 1'b0;
            end
        end
    end
endmodule // sbw_top

// ### sbw_top_properties.sv
// port assertions for the scan to bus access block
`timescale 1ns/1ps
`include "sbw_map.vh"
module sbw_top_properties (
    // clock and reset
    input wire                     core_clk,
    input wire                     rstn,
    // watched ports
    input wire                     tck,
    input wire                     tdo_q,
    input wire                     sab_req_q,
    input wire                     sab_wr_q,
    input wire [1:0]               sab_size_q,
    input wire [`SBW_ADDR_LEN-1:0] sab_addr_q,
    input wire [31:0]              sab_wdata_q,
    input wire                     sab_cancel_q,
    input wire                     sab_done
);
    // ==========================================
    // bus side
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    property p_size; sab_req_q |-> sab_size_q == `SBW_SIZE_WORD; endproperty
    a_size: assert property (p_size) else $error("bus size not word");
    property p_align; $rose(sab_req_q) |-> sab_addr_q[1:0] == 2'h0; endproperty
    a_align: assert property (p_align) else $error("bus address not word aligned");
    property p_hold;
        sab_req_q && !sab_done |=> sab_req_q && $stable(sab_addr_q) && $stable(sab_wr_q) && $stable(sab_wdata_q);
    endproperty
    a_hold: assert property (p_hold) else $error("request changed before done");
    property p_end; sab_req_q && sab_done |=> !sab_req_q; endproperty
    a_end: assert property (p_end) else $error("request held after done");
    property p_fall; $fell(sab_req_q) |-> $past(sab_done); endproperty
    a_fall: assert property (p_fall) else $error("request dropped without done");
    property p_cxl; sab_cancel_q |-> sab_req_q; endproperty
    a_cxl: assert property (p_cxl) else $error("abort without access");
    property p_cxl_end; sab_cancel_q && sab_done |=> !sab_cancel_q; endproperty
    a_cxl_end: assert property (p_cxl_end) else $error("abort held after done");
    // scan output steady for the few core clocks just after the rise
    property p_tdo; $rose(tck) |-> ##2 $stable(tdo_q) [*2]; endproperty
    a_tdo: assert property (p_tdo) else $error("scan output moved near rise");
endmodule // sbw_top_properties

// ### sbw_sab_model.sv
// bus slave: word memory with adjustable latency and a hang mode
`timescale 1ns/1ps
module sbw_sab_model (
    // clock and reset
    input  wire        core_clk,
    input  wire        rstn,
    // bus from the block
    input  wire        sab_req,
    input  wire        sab_wr,
    input  wire [35:0] sab_addr,
    input  wire [31:0] sab_wdata,
    input  wire        sab_cancel,
    output reg         sab_done,
    output reg         sab_err,
    output reg  [31:0] sab_rdata,
    // bench controls
    input  wire [7:0]  lat,
    input  wire        hang
);
    reg [31:0] mem [0:255];
    reg [7:0]  cnt_q;
    reg        act_q;
    // one access at a time; a hung access only ends by abort, with error
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            act_q <= 1'b0;
            cnt_q <= 8'h00;
            sab_done <= 1'b0;
            sab_err <= 1'b0;
            sab_rdata <= 32'h00000000;
        end else begin
            sab_done <= 1'b0;
            sab_err <= 1'b0;
            // data is not held once done has gone
            if (!sab_done) sab_rdata <= ~sab_rdata;
            if (sab_req && !act_q && !sab_done) begin
                act_q <= 1'b1;
                cnt_q <= lat;
            end else if (act_q) begin
                cnt_q <= cnt_q - 8'h01;
                if (sab_cancel || (!hang && cnt_q == 8'h00)) begin
                    act_q <= 1'b0;
                    sab_done <= 1'b1;
                    sab_err <= sab_cancel;
                    sab_rdata <= mem[sab_addr[9:2]];
                    if (sab_wr && !sab_cancel) mem[sab_addr[9:2]] <= sab_wdata;
                end
            end
        end
    end
endmodule // sbw_sab_model

// ### sbw_top_tb_top.sv
// self-checking bench for the scan word and block access block
`timescale 1ns/1ps
`include "sbw_map.vh"
module sbw_top_tb_top;
    reg         core_clk, rstn, tck, tms, tdi, protect, hang, at_sel;
    reg  [7:0]  lat;
    reg  [34:0] dout, sh;
    reg  [4:0]  cap;
    reg  [33:0] wa;
    reg  [31:0] wd;
    wire        tdo_q, tdo_oe_q, sab_req_q, sab_wr_q, sab_cancel_q, sab_done, sab_err;
    wire [1:0]  sab_size_q;
    wire [35:0] sab_addr_q;
    wire [31:0] sab_wdata_q, sab_rdata;
    integer     seed, n_mismatch, checks_done, i, j, k;
    // ==========================================
    // design and bus partner
    sbw_top sbw_top_i (.core_clk(core_clk), .rstn(rstn), .tck(tck), .tms(tms), .tdi(tdi),
        .tdo_q(tdo_q), .tdo_oe_q(tdo_oe_q), .protect(protect), .sab_req_q(sab_req_q),
        .sab_wr_q(sab_wr_q), .sab_size_q(sab_size_q), .sab_addr_q(sab_addr_q),
        .sab_wdata_q(sab_wdata_q), .sab_cancel_q(sab_cancel_q), .sab_done(sab_done),
        .sab_err(sab_err), .sab_rdata(sab_rdata));
    sbw_sab_model sbw_sab_model_i (.core_clk(core_clk), .rstn(rstn), .sab_req(sab_req_q),
        .sab_wr(sab_wr_q), .sab_addr(sab_addr_q), .sab_wdata(sab_wdata_q),
        .sab_cancel(sab_cancel_q), .sab_done(sab_done), .sab_err(sab_err),
        .sab_rdata(sab_rdata), .lat(lat), .hang(hang));
    // core clock, 8 ns
    always #4 core_clk = ~core_clk;
    // ==========================================
    // scan master; test clock only runs inside tasks
    task tstep(input m, input d);
        begin
            tms = m;
            tdi = d;
            #32;
            sh = {tdo_q, sh[34:1]};
            tck = 1'b1;
            #32;
            tck = 1'b0;
        end
    endtask
    task shift_ir(input [4:0] code);
        begin
            if (!at_sel) tstep(1, 0);
            tstep(1, 0);
            tstep(0, 0);
            tstep(0, 0);
            for (k = 0; k < 5; k = k + 1) tstep(k == 4, code[k]);
            cap = sh[34:30];
            tstep(1, 0);
            tstep(0, 0);
            at_sel = 1'b0;
        end
    endtask
    // data scan; chained scans loop straight back to select
    task shift_dr(input integer n, input [34:0] din, input chain);
        begin
            if (!at_sel) tstep(1, 0);
            tstep(0, 0);
            tstep(0, 0);
            for (k = 0; k < n; k = k + 1) tstep(k == n - 1, din[k]);
            chk_scan(tdo_oe_q, 1);
            dout = sh >> (35 - n);
            tstep(1, 0);
            tstep(chain, 0);
            at_sel = chain;
        end
    endtask
    // ==========================================
    // compare, wait and closing tasks
    // expected instruction capture: protection, error, busy, fixed tail
    function [34:0] exp_ir(input e, input b);
        begin
            exp_ir = {30'h0, protect, e, b, `SBW_IR_TAIL};
        end
    endfunction
    task chk_scan(input [34:0] got, input [34:0] exp);
        begin
            checks_done = checks_done + 1;
            if (got !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("MISMATCH t=%0t scan got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task chk_mem(input [7:0] idx, input [31:0] exp);
        begin
            checks_done = checks_done + 1;
            if (sbw_sab_model_i.mem[idx] !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("MISMATCH t=%0t memory %h exp %h", $time, sbw_sab_model_i.mem[idx], exp);
            end
        end
    endtask
    task finish_test;
        begin
            $display("checks %0d mismatches %0d", checks_done, n_mismatch);
            if (n_mismatch == 0 && checks_done > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    // bus must go quiet within a bounded time
    task wait_idle;
        begin
            for (j = 0; j < 3000 && sab_req_q !== 1'b0; j = j + 1) @(negedge core_clk);
            if (j == 3000) begin
                n_mismatch = n_mismatch + 1;
                $display("MISMATCH t=%0t bus never idle", $time);
                finish_test;
            end
        end
    endtask
    // ==========================================
    // main sequence
    initial begin
        seed = 28386;
        {core_clk, rstn, tck, tdi, hang, at_sel} = 6'h00;
        tms = 1'b1;
        lat = 8'h02;
        n_mismatch = 0;
        checks_done = 0;
        protect = $random(seed);
        for (i = 0; i < 256; i = i + 1) sbw_sab_model_i.mem[i] = $random(seed);
        repeat (3) @(posedge core_clk);
        @(negedge core_clk) rstn = 1'b1;
        repeat (3) @(negedge core_clk);
        for (i = 0; i < 6; i = i + 1) tstep(i < 5, 0);
        shift_ir(`SBW_IR_WORD);
        chk_scan(cap, exp_ir(0, 0));
        // random word writes then reads, last read cut short
        for (i = 0; i < 4; i = i + 1) begin
            wa = $random(seed);
            wd = $random(seed);
            lat = $random(seed) & 8'h0F;
            shift_dr(35, {wa, 1'b0}, 0);
            chk_scan(dout[1:0], 0);
            shift_dr(35, {wd, 3'h0}, 0);
            wait_idle;
            chk_mem(wa[7:0], wd);
            shift_dr(35, {wa, 1'b1}, 0);
            shift_dr(i == 3 ? 16 : 35, 0, 0);
            chk_scan(dout[15:0], wd[15:0]);
        end
        $display("word access test done");
        // block read after an address-only scan, chained scans
        lat = 8'h01;
        wa = $random(seed) & 34'hF0;
        shift_dr(35, {wa, 1'b1}, 0);
        shift_ir(`SBW_IR_BLOCK);
        for (i = 1; i <= 4; i = i + 1) begin
            shift_dr(34, 0, i < 4);
            chk_scan(dout[33:0], {2'h0, sbw_sab_model_i.mem[wa[7:0] + i]});
        end
        wait_idle;
        // block write after a word write
        wd = $random(seed);
        shift_ir(`SBW_IR_WORD);
        shift_dr(35, {wa, 1'b0}, 0);
        shift_dr(35, {wd, 3'h0}, 0);
        shift_ir(`SBW_IR_BLOCK);
        for (i = 1; i <= 3; i = i + 1) shift_dr(34, {1'b0, wd + i, 2'h0}, i < 3);
        wait_idle;
        for (i = 0; i <= 3; i = i + 1) chk_mem(wa[7:0] + i, wd + i);
        $display("block access test done");
        // slow read: a busy scan must not move the phase
        lat = 8'hC8;
        shift_ir(`SBW_IR_WORD);
        shift_dr(35, {wa, 1'b1}, 0);
        shift_dr(35, 0, 0);
        chk_scan(dout[32], 1);
        wait_idle;
        shift_dr(35, 0, 0);
        chk_scan(dout[33:0], {2'h0, sbw_sab_model_i.mem[wa[7:0]]});
        // hung read aborted
        hang = 1'b1;
        shift_dr(35, {wa, 1'b1}, 0);
        shift_ir(`SBW_IR_CANCEL);
        chk_scan(cap, exp_ir(0, 1));
        shift_dr(1, 1, 0);
        chk_scan(dout[0], 0);
        wait_idle;
        hang = 1'b0;
        lat = 8'h03;
        shift_ir(`SBW_IR_WORD);
        chk_scan(cap, exp_ir(1, 0));
        wd = $random(seed);
        shift_dr(35, {wa, 1'b0}, 0);
        shift_dr(35, {wd, 3'h0}, 0);
        wait_idle;
        chk_mem(wa[7:0], wd);
        shift_ir(`SBW_IR_WORD);
        chk_scan(cap, exp_ir(0, 0));
        $display("busy and abort test done");
        finish_test;
    end
endmodule // sbw_top_tb_top

bind sbw_top sbw_top_properties sbw_top_properties_i (.core_clk(core_clk), .rstn(rstn), .tck(tck),
    .tdo_q(tdo_q), .sab_req_q(sab_req_q), .sab_wr_q(sab_wr_q), .sab_size_q(sab_size_q),
    .sab_addr_q(sab_addr_q), .sab_wdata_q(sab_wdata_q), .sab_cancel_q(sab_cancel_q),
    .sab_done(sab_done));
